// [hw/led_state_pkg.sv]
// Purpose: Shared constants for the LED output-state and address-match bank
// Assumes: 8-bit register index from the serial-bus register pointer
// Notes: Reserved upper bits of the address registers are fixed patterns
package led_state_pkg;

  // Register indices
  localparam logic [7:0] IDX_STATE_LOW = 8'h0C;
  localparam logic [7:0] IDX_STATE_HIGH = 8'h0D;
  localparam logic [7:0] IDX_SUB_ONE = 8'h0E;
  localparam logic [7:0] IDX_SUB_TWO = 8'h0F;
  localparam logic [7:0] IDX_SUB_THREE = 8'h10;
  localparam logic [7:0] IDX_GROUP_CALL = 8'h11;
  // Highest index whose writes wait for stop or acknowledge
  localparam logic [7:0] IDX_LAST_DEFERRED = 8'h0D;

  // Reset values
  localparam logic [7:0] RST_STATE = 8'h00;
  localparam logic [7:0] RST_SUB_ONE = 8'h92;
  localparam logic [7:0] RST_SUB_TWO = 8'h94;
  localparam logic [7:0] RST_SUB_THREE = 8'h98;
  localparam logic [7:0] RST_GROUP_CALL = 8'h90;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Address register layout: only bits 4:1 are writable
  localparam logic [7:0] ADDR_WR_MASK = 8'h1E;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;

  // Output-state field layout
  localparam int FIELD_W = 2;
  localparam int FIELDS_PER_REG = 4;
  localparam int SUB_COUNT = 3;

  typedef enum logic [1:0] {
    CH_OFF = 2'h0,
    CH_FULL_ON = 2'h1,
    CH_OWN_PWM = 2'h2,
    CH_GROUP_PWM = 2'h3
  } chan_state_e;

endpackage

// [hw/led_output_state_and_bus_address_match.sv]
// Purpose: Output-state registers, bus sub-address and group-call registers,
//   address matcher and per-channel output selection
// Assumes: Bus controller, mode bits and PWM generators share clk
// Notes: LED output-state writes are staged and committed on stop or ack
`timescale 1ns/1ps

// Summary of operation
// - State field 00 keeps the channel off; this is the reset state.
// - State field 01 drives the channel fully on, ignoring all PWM.
// - State field 10 drives the channel from its own PWM only.
// - State field 11 combines own PWM with group dim or blink signal.
// - Low register holds channels 0-3, high 4-7, lowest channel in 1:0.
// - Sub-addresses reset to 92h, 94h, 98h, not acknowledged after reset.
// - Sub-address acknowledged only while its enable is set; host sets it last.
// - Sub-address bits 7:1 form the address; bit 0 reads 0.
// - Enabled sub-address accepted for both reads and writes.
// - Group-call address answered only while group-call enable is 1.
// - Group-call address is writable and used for reads and writes.
// - Group-call address may equal a sub-address; write is not rejected.
// - Group-call register bits 7:1 valid; bit 0 reads 0.
// - Group-call enable at 0 means that address is not acknowledged.
// - State writes commit at stop, or at each ack when update-on-ack set.
// - Per-channel PWM affects only channels in state 10 or 11.
// - While asleep, register writes are rejected and LEDs stay off.
module led_output_state_and_bus_address_match #(
  parameter int NUM_CHANNELS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the bus controller
  input wire logic regWrEn,
  input wire logic [7:0] regIndex,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regHit,
  // Bus frame events
  input wire logic busAckPulse,
  input wire logic busStopPulse,
  // Address phase
  input wire logic addrValid,
  input wire logic [6:0] addrIn,
  input wire logic [6:0] hwAddr,
  output logic addrMatch,
  // Mode bits held elsewhere
  input wire logic sleepMode,
  input wire logic updateOnAcknowledge,
  input wire logic [2:0] subAddressRespondEnable,
  input wire logic groupCallEnable,
  // PWM sources
  input wire logic [NUM_CHANNELS-1:0] channelPwm,
  input wire logic groupPwm,
  // Open-drain LED sinks: enable high while the output pulls low, data held at 0
  output logic [NUM_CHANNELS-1:0] ledSinkOut,
  output logic [NUM_CHANNELS-1:0] ledSinkOe
);

  localparam int STATE_BITS = NUM_CHANNELS * led_state_pkg::FIELD_W;
  localparam int REG_CH = led_state_pkg::FIELDS_PER_REG;

  // Only two output-state registers exist to hold the fields
  if (NUM_CHANNELS != 2 * REG_CH)
  begin : g_bad_channels
    $error("NUM_CHANNELS must equal two output-state registers");
  end

  // Committed and staged output-state words
  logic [7:0] stateLow_ff;
  logic [7:0] stateHigh_ff;
  logic [7:0] pendLow_ff;
  logic [7:0] pendHigh_ff;
  logic pendDirty_ff;
  // Address registers
  logic [7:0] subOne_ff;
  logic [7:0] subTwo_ff;
  logic [7:0] subThree_ff;
  logic [7:0] groupCall_ff;
  // Registered outputs
  logic [7:0] regRdData_ff;
  logic regHit_ff;
  logic addrMatch_ff;
  logic [NUM_CHANNELS-1:0] ledSink_ff;

  logic wrAccept;
  logic commitNow;
  logic [7:0] nxt_pendLow;
  logic [7:0] nxt_pendHigh;
  logic [STATE_BITS-1:0] stateVec;

  // Merge a write into an address register, keeping reserved bits
  function automatic logic [7:0] addr_merge(input logic [7:0] cur,
                                            input logic [7:0] wd);
    addr_merge = (cur & ~led_state_pkg::ADDR_WR_MASK) |
                 (wd & led_state_pkg::ADDR_WR_MASK);
  endfunction

  // Compare a received address with bits 7:1 of a register
  function automatic logic addr_hit(input logic [7:0] regVal,
                                    input logic [6:0] rx);
    addr_hit = (regVal[led_state_pkg::ADDR_MSB:led_state_pkg::ADDR_LSB]
                == rx);
  endfunction

  // Sink decision for one channel from its state field
  function automatic logic chan_drive(input logic [1:0] field,
                                      input logic ownPwm,
                                      input logic group_duty_register);
    logic res;
    res = 1'b0;
    case (led_state_pkg::chan_state_e'(field))
      led_state_pkg::CH_OFF: res = 1'b0;
      led_state_pkg::CH_FULL_ON: res = 1'b1;
      led_state_pkg::CH_OWN_PWM: res = ownPwm;
      led_state_pkg::CH_GROUP_PWM: res = ownPwm & group_duty_register;
      default: res = 1'b0;
    endcase
    chan_drive = res;
  endfunction

  // Writes are dropped entirely while the oscillator sleeps
  assign wrAccept = regWrEn & ~sleepMode;

  // Commit at stop, or at every ack when update-on-ack is selected
  assign commitNow = busStopPulse |
                     (busAckPulse & updateOnAcknowledge);

  always_comb
  begin
    nxt_pendLow = pendLow_ff;
    nxt_pendHigh = pendHigh_ff;
    if (wrAccept && regIndex == led_state_pkg::IDX_STATE_LOW)
      nxt_pendLow = regWrData;
    if (wrAccept && regIndex == led_state_pkg::IDX_STATE_HIGH)
      nxt_pendHigh = regWrData;
  end

  // Staging for deferred output-state writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendLow_ff <= led_state_pkg::RST_STATE;
      pendHigh_ff <= led_state_pkg::RST_STATE;
    end
    else
    begin
      pendLow_ff <= nxt_pendLow;
      pendHigh_ff <= nxt_pendHigh;
    end
  end

  // A write landing together with its commit event is not lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pendDirty_ff <= 1'b0;
    else if (wrAccept && regIndex <= led_state_pkg::IDX_LAST_DEFERRED &&
             (regIndex == led_state_pkg::IDX_STATE_LOW ||
              regIndex == led_state_pkg::IDX_STATE_HIGH))
      pendDirty_ff <= 1'b1;
    else if (commitNow)
      pendDirty_ff <= 1'b0;
  end

  // Committed output-state registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateLow_ff <= led_state_pkg::RST_STATE;
      stateHigh_ff <= led_state_pkg::RST_STATE;
    end
    else if (commitNow)
    begin
      stateLow_ff <= nxt_pendLow;
      stateHigh_ff <= nxt_pendHigh;
    end
  end

  // Address registers take effect at once; only bits 4:1 move
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      subOne_ff <= led_state_pkg::RST_SUB_ONE;
      subTwo_ff <= led_state_pkg::RST_SUB_TWO;
      subThree_ff <= led_state_pkg::RST_SUB_THREE;
    end
    else if (wrAccept)
    begin
      if (regIndex == led_state_pkg::IDX_SUB_ONE)
        subOne_ff <= addr_merge(subOne_ff, regWrData);
      if (regIndex == led_state_pkg::IDX_SUB_TWO)
        subTwo_ff <= addr_merge(subTwo_ff, regWrData);
      if (regIndex == led_state_pkg::IDX_SUB_THREE)
        subThree_ff <= addr_merge(subThree_ff, regWrData);
    end
  end

  // Any value is accepted, even one that duplicates a sub-address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      groupCall_ff <= led_state_pkg::RST_GROUP_CALL;
    else if (wrAccept && regIndex == led_state_pkg::IDX_GROUP_CALL)
      groupCall_ff <= addr_merge(groupCall_ff, regWrData);
  end

  // Read path shows committed state, one cycle after the index
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData_ff <= led_state_pkg::RD_UNMAPPED;
      regHit_ff <= 1'b0;
    end
    else
    begin
      regHit_ff <= 1'b1;
      case (regIndex)
        led_state_pkg::IDX_STATE_LOW: regRdData_ff <= stateLow_ff;
        led_state_pkg::IDX_STATE_HIGH: regRdData_ff <= stateHigh_ff;
        led_state_pkg::IDX_SUB_ONE: regRdData_ff <= subOne_ff;
        led_state_pkg::IDX_SUB_TWO: regRdData_ff <= subTwo_ff;
        led_state_pkg::IDX_SUB_THREE: regRdData_ff <= subThree_ff;
        led_state_pkg::IDX_GROUP_CALL: regRdData_ff <= groupCall_ff;
        default:
        begin
          regRdData_ff <= led_state_pkg::RD_UNMAPPED;
          regHit_ff <= 1'b0;
        end
      endcase
    end
  end

  // Address matcher; the direction bit is not looked at, so reads and
  // writes are treated alike
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      addrMatch_ff <= 1'b0;
    else if (addrValid)
      addrMatch_ff <= (hwAddr == addrIn) |
        (subAddressRespondEnable[0] & addr_hit(subOne_ff, addrIn)) |
        (subAddressRespondEnable[1] & addr_hit(subTwo_ff, addrIn)) |
        (subAddressRespondEnable[2] & addr_hit(subThree_ff, addrIn)) |
        (groupCallEnable & addr_hit(groupCall_ff, addrIn));
    else
      addrMatch_ff <= 1'b0;
  end

  assign stateVec = {stateHigh_ff, stateLow_ff};

  // Channel output selection; sleep forces every sink off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ledSink_ff <= '0;
    else
      for (int ch = 0; ch < NUM_CHANNELS; ch++)
        ledSink_ff[ch] <= ~sleepMode & chan_drive(
          stateVec[ch*led_state_pkg::FIELD_W +: led_state_pkg::FIELD_W],
          channelPwm[ch], groupPwm);
  end

  // Open-drain: the pin is driven only while it sinks, and then low
  assign ledSinkOut = '0;
  assign ledSinkOe = ledSink_ff;
  assign regRdData = regRdData_ff;
  assign regHit = regHit_ff;
  assign addrMatch = addrMatch_ff;

endmodule

// [verification/led_state_asserts.sv]
// Purpose: Port-level checks of the LED state and address bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the design from tb_top
`timescale 1ns/1ps
module led_state_asserts #(
  parameter int NUM_CHANNELS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic regWrEn,
  input wire logic [7:0] regIndex,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regHit,
  // Address phase, mode and LED sinks
  input wire logic addrValid,
  input wire logic [6:0] addrIn,
  input wire logic [6:0] hwAddr,
  input wire logic addrMatch,
  input wire logic sleepMode,
  input wire logic [NUM_CHANNELS-1:0] ledSinkOut,
  input wire logic [NUM_CHANNELS-1:0] ledSinkOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic isAddr;
  assign isAddr = regIndex inside {[8'h0E:8'h11]};
  a_map_hit: assert property (regIndex inside {[8'h0C:8'h11]} |=> regHit)
    else $error("mapped index gave no hit");
  a_addr_fixed: assert property (
    isAddr |=> regRdData[7:5] == 3'h4 && !regRdData[0])
    else $error("fixed address bits wrong");
  a_sub_write: assert property (
    (regWrEn && !sleepMode && isAddr) ##1 (!regWrEn && $stable(regIndex))
    ##1 (!regWrEn && $stable(regIndex))
    |=> regRdData[4:1] == $past(regWrData[4:1], 3))
    else $error("address write not applied");
  a_sleep_drop: assert property (
    (regWrEn && sleepMode && isAddr) ##1 (!regWrEn && $stable(regIndex))
    |=> $stable(regRdData))
    else $error("write accepted while asleep");
  a_match_cause: assert property (!addrValid |=> !addrMatch)
    else $error("match without address phase");
  a_hw_match: assert property (addrValid && addrIn == hwAddr |=> addrMatch)
    else $error("own address not matched");
  a_sleep_dark: assert property (sleepMode |=> ledSinkOe == '0)
    else $error("LED on while asleep");
  a_sink_low: assert property (ledSinkOe != '0 |-> ledSinkOut == '0)
    else $error("sink drives high");
endmodule

// [verification/bus_ctrl_model.sv]
// Purpose: Serial-bus controller model for the register port
// Assumes: Bus events arrive already decoded, one byte per strobe
// Notes: Released data lines show the inverse of their last value
`timescale 1ns/1ps
module bus_ctrl_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic regWrEn,
  output logic [7:0] regIndex,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regHit,
  // Frame events and address phase
  output logic busAckPulse,
  output logic busStopPulse,
  output logic addrValid,
  output logic [6:0] addrIn,
  input wire logic addrMatch
);
  initial
  begin
    regWrEn = 1'b0;
    regIndex = 8'h00;
    regWrData = 8'h00;
    busAckPulse = 1'b0;
    busStopPulse = 1'b0;
    addrValid = 1'b0;
    addrIn = 7'h00;
  end
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clk);
    regWrEn <= 1'b1;
    regIndex <= idx;
    regWrData <= dat;
    @(posedge clk);
    regWrEn <= 1'b0;
    regWrData <= ~dat;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat,
                    output logic hit);
    @(posedge clk);
    regIndex <= idx;
    @(posedge clk);
    @(negedge clk);
    dat = regRdData;
    hit = regHit;
  endtask
  task automatic frame(input logic stop);
    @(posedge clk);
    busStopPulse <= stop;
    busAckPulse <= !stop;
    @(posedge clk);
    busStopPulse <= 1'b0;
    busAckPulse <= 1'b0;
  endtask
  task automatic call(input logic [6:0] a, output logic m);
    @(posedge clk);
    addrValid <= 1'b1;
    addrIn <= a;
    @(posedge clk);
    addrValid <= 1'b0;
    addrIn <= ~a;
    @(negedge clk);
    m = addrMatch;
  endtask
endmodule

// [verification/tb_top.sv]
// Purpose: Directed bench for the LED state and address bank
// Assumes: Controller model drives the register port and bus events
// Notes: Expected values follow the register layout
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, sleepMode, updateOnAcknowledge, groupCallEnable, groupPwm;
  logic [2:0] subAddressRespondEnable;
  logic [6:0] hwAddr, addrIn;
  logic [7:0] channelPwm, regIndex, regWrData, regRdData, ledSinkOut, ledSinkOe;
  logic regWrEn, regHit, busAckPulse, busStopPulse, addrValid, addrMatch;
  logic [7:0] rd;
  logic hit, m;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] rstVal [6] = '{8'h00, 8'h00, 8'h92, 8'h94, 8'h98, 8'h90};
  logic [7:0] oeLow [3] = '{8'h02, 8'h06, 8'h0E};
  led_output_state_and_bus_address_match i_led_output_state_and_bus_address_match (
    .clk, .rst_n, .regWrEn, .regIndex, .regWrData, .regRdData, .regHit,
    .busAckPulse, .busStopPulse, .addrValid, .addrIn, .hwAddr, .addrMatch,
    .sleepMode, .updateOnAcknowledge, .subAddressRespondEnable,
    .groupCallEnable, .channelPwm, .groupPwm, .ledSinkOut, .ledSinkOe);
  bus_ctrl_model i_bus_ctrl_model (.clk, .regWrEn, .regIndex, .regWrData,
    .regRdData, .regHit, .busAckPulse, .busStopPulse, .addrValid, .addrIn,
    .addrMatch);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    i_bus_ctrl_model.rd(idx, rd, hit);
    chk(rd, exp);
    chk({7'h0, hit}, {7'h0, idx inside {[8'h0C:8'h11]}});
  endtask
  task automatic achk(input logic [6:0] a, input logic exp);
    i_bus_ctrl_model.call(a, m);
    chk({7'h0, m}, {7'h0, exp});
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    // Wide margin over the fewer than a hundred cycles the sequence needs
    #20000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    sleepMode = 1'b0;
    updateOnAcknowledge = 1'b0;
    groupCallEnable = 1'b1;
    groupPwm = 1'b0;
    subAddressRespondEnable = 3'h0;
    hwAddr = 7'h2A;
    channelPwm = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rchk(8'h0C + i[7:0], rstVal[i]);
    rchk(8'h0B, 8'h00);
    achk(7'h2A, 1'b1);
    achk(7'h48, 1'b1);
    for (int i = 2; i < 5; i++)
      achk(rstVal[i][7:1], 1'b0);
    groupCallEnable <= 1'b0;
    achk(7'h48, 1'b0);
    i_bus_ctrl_model.wr(8'h0E, 8'hFF);
    rchk(8'h0E, 8'h9E);
    achk(7'h4F, 1'b0);
    // Enable only after the address is in place
    subAddressRespondEnable <= 3'h1;
    achk(7'h4F, 1'b1);
    i_bus_ctrl_model.wr(8'h11, 8'h9E);
    rchk(8'h11, 8'h9E);
    groupCallEnable <= 1'b1;
    subAddressRespondEnable <= 3'h0;
    achk(7'h4F, 1'b1);
    i_bus_ctrl_model.wr(8'h0C, 8'hE4);
    rchk(8'h0C, 8'h00);
    i_bus_ctrl_model.frame(1'b1);
    rchk(8'h0C, 8'hE4);
    updateOnAcknowledge <= 1'b1;
    i_bus_ctrl_model.wr(8'h0D, 8'h1B);
    i_bus_ctrl_model.frame(1'b0);
    rchk(8'h0D, 8'h1B);
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clk);
      channelPwm <= (j > 0) ? 8'hFF : 8'h00;
      groupPwm <= (j == 2);
      @(posedge clk);
      @(negedge clk);
      chk({4'h0, ledSinkOe[3:0]}, oeLow[j]);
    end
    chk({4'h0, ledSinkOe[7:4]}, 8'h07);
    chk(ledSinkOut, 8'h00);
    sleepMode <= 1'b1;
    i_bus_ctrl_model.wr(8'h0E, 8'h00);
    rchk(8'h0E, 8'h9E);
    chk(ledSinkOe, 8'h00);
    end_of_test();
  end
endmodule
bind led_output_state_and_bus_address_match led_state_asserts #(
  .NUM_CHANNELS(NUM_CHANNELS)) i_led_state_asserts (.clk, .rst_n, .regWrEn,
  .regIndex, .regWrData, .regRdData, .regHit, .addrValid, .addrIn, .hwAddr,
  .addrMatch, .sleepMode, .ledSinkOut, .ledSinkOe);
